/* File: logic/abm_defs.vh */
// Register indices, field positions, reset values and counts of the monitor
`ifndef ABM_DEFS_VH
`define ABM_DEFS_VH
`define ABM_IDX_INT_EN 8'he0
`define ABM_IDX_INT_STAT 8'he1
`define ABM_IDX_CFG 8'he2
`define ABM_IDX_SF_PER 8'he3
`define ABM_IDX_SF_SAT 8'he6
`define ABM_IDX_SF_DECL 8'he8
`define ABM_IDX_SF_CLR 8'hea
`define ABM_IDX_SD_PER 8'hec
`define ABM_IDX_SD_SAT 8'hef
`define ABM_IDX_SD_DECL 8'hf1
`define ABM_IDX_SD_CLR 8'hf3
`define ABM_IDX_K1 8'hf5
`define ABM_IDX_K2 8'hf6
`define ABM_IDX_SYNC 8'hf7
`define ABM_EN_MASK 8'hf8
`define ABM_CFG_RST 8'h00
`define ABM_CFG_SYNC_PERSIST 7
`define ABM_CFG_SF_EN 6
`define ABM_CFG_SF_SAT 5
`define ABM_CFG_SF_CLR 4
`define ABM_CFG_SD_EN 3
`define ABM_CFG_SD_SAT 2
`define ABM_CFG_SD_CLR 1
`define ABM_APS_PERSIST 2'h3
`define ABM_SYNC_PERSIST 3'h7
`define ABM_PSBF_FRAMES 4'hc
`define ABM_LONG_SUBS 6'h3f
`define ABM_RESP_OKAY 2'h0
`define ABM_RESP_SLVERR 2'h2
`endif

/* File: logic/abm_monitor.v */
// Line BER alarms, APS byte and sync message monitor with AXI4-Lite registers
// Functional notes
// - Degrade enable passes degrade transitions to interrupt
// - Fail enable passes fail transitions to interrupt
// - Sync enable interrupts on new sync message
// - APS enable interrupts on new K1/K2 code
// - Switch-byte enable passes failure transitions to interrupt
// - Failure after twelve frames without K1 triple
// - Failure clears after three identical K1 frames
// - Degrade alarm follows declare and clear thresholds
// - Fail alarm follows declare and clear thresholds
// - Degrade event set on any alarm change
// - Fail event set on any alarm change
// - Sync event set on new stored message
// - APS event set on new stored code
// - Switch-byte event set on failure changes
// - Status read clears events, not alarm states
// - Degrade clear window same or eight times
// - Fail clear window same or eight times
// - Degrade saturation per frame or per subtotal
// - Fail saturation per frame or per subtotal
// - Degrade enable runs accumulation, else resets
// - Fail enable runs accumulation, else resets
// - Sync persistence needs eight equal frames
// - Fail declares at or above threshold
// - Window is eight sliding frame subtotals
// - K1 stored after three new identical frames
`timescale 1ns/1ns
`default_nettype none
`include "abm_defs.vh"
module abm_monitor (
  input wire clk,
  input wire srst,
  // Per-frame overhead from the line processor
  input wire frameStrobe,
  input wire [11:0] b2ErrCount,
  input wire [7:0] k1Byte,
  input wire [7:0] k2Byte,
  input wire [3:0] syncNibble,
  // AXI4-Lite slave
  input wire [11:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [11:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  output wire irq
);

  // Add two counts and hold the result at a cap
  function [11:0] capAdd;
    input [11:0] a;
    input [11:0] b;
    input [11:0] cap;
    reg [12:0] s;
    begin
      s = {1'b0, a} + {1'b0, b};
      capAdd = (s > {1'b0, cap}) ? cap : s[11:0];
    end
  endfunction

  // Byte-lane merge of a write into an old word
  function [31:0] laneMerge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0] strb;
    integer b;
    begin
      laneMerge = old;
      for (b = 0; b < 4; b = b + 1) begin
        if (strb[b]) begin
          laneMerge[b*8 +: 8] = nw[b*8 +: 8];
        end
      end
    end
  endfunction

  // Software registers
  reg [7:0] intEn_r; // Only bits 7..3 are stored
  reg [7:0] cfg_r;
  reg [23:0] sfPer_r, sdPer_r;
  reg [11:0] sfSat_r, sfDecl_r, sfClr_r;
  reg [11:0] sdSat_r, sdDecl_r, sdClr_r;
  reg [4:0] evt_r; // {switch, aps, sync, fail, degrade}
  reg psbf_r; // Switch-byte failure state
  reg [7:0] k1Stored_r, k2Stored_r;
  reg [3:0] syncStored_r;
  // Alarm states and their pending changes, one bit per monitor
  wire [1:0] alarmVec;
  wire [1:0] alarmFlip;

  // Bus handshake state
  reg awHeld_r, wHeld_r;
  reg [7:0] wIdx_r;
  reg [31:0] wData_r;
  reg [3:0] wStrb_r;

  // Write channels stall while a response is pending
  assign s_axi_awready = !awHeld_r && !s_axi_bvalid;
  assign s_axi_wready = !wHeld_r && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;

  wire awFire = s_axi_awvalid && s_axi_awready;
  wire wFire = s_axi_wvalid && s_axi_wready;
  wire arFire = s_axi_arvalid && s_axi_arready;
  // Write commits one cycle after both halves are held
  wire doWrite = awHeld_r && wHeld_r;
  wire [7:0] rIdx = s_axi_araddr[9:2];
  wire addrHi = s_axi_araddr[11:10] != 2'b00;

  // Write index decode; anything else answers with an error
  function mapped;
    input [7:0] idx;
    begin
      case (idx)
        `ABM_IDX_INT_EN, `ABM_IDX_INT_STAT, `ABM_IDX_CFG,
        `ABM_IDX_SF_PER, `ABM_IDX_SF_SAT, `ABM_IDX_SF_DECL,
        `ABM_IDX_SF_CLR, `ABM_IDX_SD_PER, `ABM_IDX_SD_SAT,
        `ABM_IDX_SD_DECL, `ABM_IDX_SD_CLR, `ABM_IDX_K1,
        `ABM_IDX_K2, `ABM_IDX_SYNC: mapped = 1'b1;
        default: mapped = 1'b0;
      endcase
    end
  endfunction

  // Address and data capture, in either order
  always @(posedge clk) begin
    if (srst) begin
      awHeld_r <= 1'b0;
      wHeld_r <= 1'b0;
      wIdx_r <= 8'h00;
      wData_r <= 32'h0;
      wStrb_r <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `ABM_RESP_OKAY;
    end else begin
      if (awFire) begin
        awHeld_r <= 1'b1;
        // Upper address bits out of map force a miss
        wIdx_r <= (s_axi_awaddr[11:10] != 2'b00) ? 8'h00 : s_axi_awaddr[9:2];
      end
      if (wFire) begin
        wHeld_r <= 1'b1;
        wData_r <= s_axi_wdata;
        wStrb_r <= s_axi_wstrb;
      end
      if (doWrite) begin
        awHeld_r <= 1'b0;
        wHeld_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= mapped(wIdx_r) ? `ABM_RESP_OKAY : `ABM_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Current contents of the written register, for byte-lane merging
  reg [31:0] wrOld;
  always @* begin
    case (wIdx_r)
      `ABM_IDX_INT_EN: wrOld = {24'h0, intEn_r};
      `ABM_IDX_CFG: wrOld = {24'h0, cfg_r};
      `ABM_IDX_SF_PER: wrOld = {8'h0, sfPer_r};
      `ABM_IDX_SF_SAT: wrOld = {20'h0, sfSat_r};
      `ABM_IDX_SF_DECL: wrOld = {20'h0, sfDecl_r};
      `ABM_IDX_SF_CLR: wrOld = {20'h0, sfClr_r};
      `ABM_IDX_SD_PER: wrOld = {8'h0, sdPer_r};
      `ABM_IDX_SD_SAT: wrOld = {20'h0, sdSat_r};
      `ABM_IDX_SD_DECL: wrOld = {20'h0, sdDecl_r};
      `ABM_IDX_SD_CLR: wrOld = {20'h0, sdClr_r};
      default: wrOld = 32'h0;
    endcase
  end
  // Merged word; each register keeps only its own low bits
  wire [31:0] wrWord = laneMerge(wrOld, wData_r, wStrb_r);

  // Register writes; status, K1, K2 and sync words are read-only
  always @(posedge clk) begin
    if (srst) begin
      intEn_r <= 8'h00;
      cfg_r <= `ABM_CFG_RST;
      sfPer_r <= 24'h0;
      sdPer_r <= 24'h0;
      sfSat_r <= 12'h0;
      sfDecl_r <= 12'h0;
      sfClr_r <= 12'h0;
      sdSat_r <= 12'h0;
      sdDecl_r <= 12'h0;
      sdClr_r <= 12'h0;
    end else if (doWrite) begin
      case (wIdx_r)
        `ABM_IDX_INT_EN: intEn_r <= wrWord[7:0] & `ABM_EN_MASK;
        `ABM_IDX_CFG: cfg_r <= wrWord[7:0];
        `ABM_IDX_SF_PER: sfPer_r <= wrWord[23:0];
        `ABM_IDX_SF_SAT: sfSat_r <= wrWord[11:0];
        `ABM_IDX_SF_DECL: sfDecl_r <= wrWord[11:0];
        `ABM_IDX_SF_CLR: sfClr_r <= wrWord[11:0];
        `ABM_IDX_SD_PER: sdPer_r <= wrWord[23:0];
        `ABM_IDX_SD_SAT: sdSat_r <= wrWord[11:0];
        `ABM_IDX_SD_DECL: sdDecl_r <= wrWord[11:0];
        `ABM_IDX_SD_CLR: sdClr_r <= wrWord[11:0];
        default: ;
      endcase
    end
  end

  // Read mux
  reg [31:0] rMux;
  always @* begin
    case (rIdx)
      `ABM_IDX_INT_EN: rMux = {24'h0, intEn_r};
      `ABM_IDX_INT_STAT: rMux = {24'h0, evt_r, alarmVec[1], alarmVec[0], psbf_r};
      `ABM_IDX_CFG: rMux = {24'h0, cfg_r};
      `ABM_IDX_SF_PER: rMux = {8'h0, sfPer_r};
      `ABM_IDX_SF_SAT: rMux = {20'h0, sfSat_r};
      `ABM_IDX_SF_DECL: rMux = {20'h0, sfDecl_r};
      `ABM_IDX_SF_CLR: rMux = {20'h0, sfClr_r};
      `ABM_IDX_SD_PER: rMux = {8'h0, sdPer_r};
      `ABM_IDX_SD_SAT: rMux = {20'h0, sdSat_r};
      `ABM_IDX_SD_DECL: rMux = {20'h0, sdDecl_r};
      `ABM_IDX_SD_CLR: rMux = {20'h0, sdClr_r};
      `ABM_IDX_K1: rMux = {24'h0, k1Stored_r};
      `ABM_IDX_K2: rMux = {24'h0, k2Stored_r};
      `ABM_IDX_SYNC: rMux = {28'h0, syncStored_r};
      default: rMux = 32'h0;
    endcase
  end

  // Read channel; the answer is registered one cycle after the address
  always @(posedge clk) begin
    if (srst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= `ABM_RESP_OKAY;
    end else if (arFire) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= addrHi ? 32'h0 : rMux;
      s_axi_rresp <= (!addrHi && mapped(rIdx)) ? `ABM_RESP_OKAY : `ABM_RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Bit error monitors: channel 0 is degrade, channel 1 is fail
  genvar ch;
  generate
    for (ch = 0; ch < 2; ch = ch + 1) begin : gBer
      wire monEn = (ch == 0) ? cfg_r[`ABM_CFG_SD_EN] : cfg_r[`ABM_CFG_SF_EN];
      wire satMode = (ch == 0) ? cfg_r[`ABM_CFG_SD_SAT] : cfg_r[`ABM_CFG_SF_SAT];
      wire clrMode = (ch == 0) ? cfg_r[`ABM_CFG_SD_CLR] : cfg_r[`ABM_CFG_SF_CLR];
      wire [23:0] period = (ch == 0) ? sdPer_r : sfPer_r;
      wire [11:0] satTh = (ch == 0) ? sdSat_r : sfSat_r;
      wire [11:0] declTh = (ch == 0) ? sdDecl_r : sfDecl_r;
      wire [11:0] clrTh = (ch == 0) ? sdClr_r : sfClr_r;
      reg [11:0] sub_r [0:7]; // Sliding subtotals
      reg [2:0] ptr_r; // Oldest subtotal slot
      reg [23:0] frm_r; // Frames into current subtotal
      reg [11:0] acc_r; // Current subtotal
      reg [14:0] win_r; // Sum of the eight subtotals
      reg [17:0] long_r; // Long clearing window sum
      reg [5:0] longCnt_r; // Subtotals into long window
      reg alarm_r;
      reg alarmNxt;
      integer i;
      // per-frame cap when mode is zero
      wire [11:0] frmErr = satMode ? b2ErrCount : capAdd(12'h0, b2ErrCount, satTh);
      wire [11:0] accSum = capAdd(acc_r, frmErr, satMode ? satTh : 12'hfff);
      // A zero period still closes a subtotal every frame
      wire subEnd = ({1'b0, frm_r} + 25'h1) >= {1'b0, period};
      wire [14:0] winNew = win_r - {3'b0, sub_r[ptr_r]} + {3'b0, accSum};
      wire [17:0] longNew = long_r + {6'b0, accSum};

      // Alarm decision taken only when a subtotal closes; disabling the monitor clears it at once
      always @* begin
        alarmNxt = alarm_r;
        if (!monEn) begin
          alarmNxt = 1'b0;
        end else if (frameStrobe && subEnd) begin
          if (!alarm_r) begin
            alarmNxt = winNew >= {3'b0, declTh};
          end else if (!clrMode) begin
            alarmNxt = !(winNew < {3'b0, clrTh});
          end else if (longCnt_r == `ABM_LONG_SUBS) begin
            alarmNxt = !(longNew < {6'b0, clrTh});
          end
        end
      end

      always @(posedge clk) begin
        if (srst || !monEn) begin
          for (i = 0; i < 8; i = i + 1) begin
            sub_r[i] <= 12'h0;
          end
          ptr_r <= 3'h0;
          frm_r <= 24'h0;
          acc_r <= 12'h0;
          win_r <= 15'h0;
          long_r <= 18'h0;
          longCnt_r <= 6'h0;
          alarm_r <= 1'b0;
        end else begin
          alarm_r <= alarmNxt;
          if (frameStrobe) begin
            if (subEnd) begin
              sub_r[ptr_r] <= accSum;
              ptr_r <= ptr_r + 3'h1;
              win_r <= winNew;
              frm_r <= 24'h0;
              acc_r <= 12'h0;
              // Long window only runs while declared in long mode
              if (!alarm_r || !clrMode || longCnt_r == `ABM_LONG_SUBS) begin
                long_r <= 18'h0;
                longCnt_r <= 6'h0;
              end else begin
                long_r <= longNew;
                longCnt_r <= longCnt_r + 6'h1;
              end
            end else begin
              frm_r <= frm_r + 24'h1;
              acc_r <= accSum;
            end
          end
        end
      end
      assign alarmVec[ch] = alarm_r;
      assign alarmFlip[ch] = alarm_r != alarmNxt;
    end
  endgenerate

  // K1 run tracking for switch-byte failure, pair tracking for code updates
  reg [7:0] k1Last_r, k2Last_r;
  reg [1:0] k1Run_r; // Identical K1 frames, saturates at three
  reg [1:0] apsRun_r; // Identical K1/K2 pair frames, saturates at three
  reg [3:0] noRunCnt_r; // Frames since last K1 triple or failure declaration
  reg [3:0] syncLast_r;
  reg [2:0] syncRun_r; // Equal nibble frames minus one
  wire [1:0] k1RunNxt = (k1Byte != k1Last_r) ? 2'h1 :
                        (k1Run_r == `ABM_APS_PERSIST) ? k1Run_r : k1Run_r + 2'h1;
  wire k1Triple = k1RunNxt == `ABM_APS_PERSIST;
  wire pairSame = (k1Byte == k1Last_r) && (k2Byte == k2Last_r);
  wire pairNew = (k1Byte != k1Stored_r) || (k2Byte != k2Stored_r);
  wire [1:0] apsRunNxt = !pairSame ? 2'h1 :
                         (apsRun_r == `ABM_APS_PERSIST) ? apsRun_r : apsRun_r + 2'h1;
  // update after three new identical frames
  wire apsLoad = frameStrobe && pairNew && apsRunNxt == `ABM_APS_PERSIST;
  // failure after twelve frames without triple
  wire psbfSet = frameStrobe && !k1Triple && (noRunCnt_r + 4'h1 >= `ABM_PSBF_FRAMES);
  wire psbfClr = frameStrobe && k1Triple;
  wire psbfNxt = psbfClr ? 1'b0 : (psbfSet ? 1'b1 : psbf_r);
  wire syncSame = syncNibble == syncLast_r;
  // eight equal frames when persistence is on
  wire syncOk = !cfg_r[`ABM_CFG_SYNC_PERSIST] ||
                (syncSame && syncRun_r == `ABM_SYNC_PERSIST - 3'h1) ||
                (syncSame && syncRun_r == `ABM_SYNC_PERSIST);
  wire syncLoad = frameStrobe && syncOk && (syncNibble != syncStored_r);

  // Frame-rate state for APS and sync extraction
  always @(posedge clk) begin
    if (srst) begin
      k1Last_r <= 8'h00;
      k2Last_r <= 8'h00;
      k1Run_r <= 2'h0;
      apsRun_r <= 2'h0;
      noRunCnt_r <= 4'h0;
      psbf_r <= 1'b0;
      k1Stored_r <= 8'h00;
      k2Stored_r <= 8'h00;
      syncLast_r <= 4'h0;
      syncRun_r <= 3'h0;
      syncStored_r <= 4'h0;
    end else if (frameStrobe) begin
      k1Last_r <= k1Byte;
      k2Last_r <= k2Byte;
      k1Run_r <= k1RunNxt;
      apsRun_r <= apsRunNxt;
      noRunCnt_r <= (k1Triple || psbfSet) ? 4'h0 : noRunCnt_r + 4'h1;
      psbf_r <= psbfNxt;
      if (apsLoad) begin
        k1Stored_r <= k1Byte;
        k2Stored_r <= k2Byte;
      end
      syncLast_r <= syncNibble;
      // Run count saturates so a held value stays qualified
      syncRun_r <= !syncSame ? 3'h0 :
                   (syncRun_r == `ABM_SYNC_PERSIST) ? syncRun_r : syncRun_r + 3'h1;
      if (syncLoad) begin
        syncStored_r <= syncNibble;
      end
    end
  end

  // Event bits; a new event in the clearing cycle survives the read
  wire statRead = arFire && !addrHi && rIdx == `ABM_IDX_INT_STAT;
  wire [4:0] evtSet = {psbfNxt != psbf_r, apsLoad, syncLoad, alarmFlip[1], alarmFlip[0]};
  always @(posedge clk) begin
    if (srst) begin
      evt_r <= 5'h00;
    end else begin
      evt_r <= (statRead ? 5'h00 : evt_r) | evtSet;
    end
  end

  assign irq = |(evt_r & intEn_r[7:3]);

endmodule
`default_nettype wire

/* File: test/abm_frame_src.sv */
// Line overhead source that hands one frame of bytes to the monitor
`timescale 1ns/1ns
`default_nettype none
module abm_frame_src (
  input wire logic clk,
  output logic frameStrobe,
  output logic [11:0] b2ErrCount,
  output logic [7:0] k1Byte,
  output logic [7:0] k2Byte,
  output logic [3:0] syncNibble
);
  // Quiet until the first frame
  initial begin
    frameStrobe = 1'b0;
    b2ErrCount = 12'h0;
    k1Byte = 8'h0;
    k2Byte = 8'h0;
    syncNibble = 4'h0;
  end
  // One frame; bytes mean nothing off the strobe, so they are inverted there
  task send(input logic [7:0] k1, input logic [7:0] k2, input logic [3:0] sn,
            input logic [11:0] err, input int gap);
    frameStrobe <= 1'b1;
    b2ErrCount <= err;
    k1Byte <= k1;
    k2Byte <= k2;
    syncNibble <= sn;
    @(posedge clk);
    frameStrobe <= 1'b0;
    b2ErrCount <= ~err;
    k1Byte <= ~k1;
    k2Byte <= ~k2;
    syncNibble <= ~sn;
    repeat (gap) @(posedge clk);
  endtask
endmodule
`default_nettype wire

/* File: test/abm_monitor_properties.sv */
// Bus timing and interrupt properties of the monitor
`timescale 1ns/1ns
`default_nettype none
`include "abm_defs.vh"
module abm_monitor_properties (
  input wire logic clk,
  input wire logic srst,
  input wire logic frameStrobe,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  // Read of the event register taken
  sequence statRead;
    s_axi_arvalid && s_axi_arready && s_axi_araddr == {2'h0, `ABM_IDX_INT_STAT, 2'h0};
  endsequence
  // Read of the enable register taken
  sequence enRead;
    s_axi_arvalid && s_axi_arready && s_axi_araddr == {2'h0, `ABM_IDX_INT_EN, 2'h0};
  endsequence
  // Address and data taken together
  sequence wrBoth;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  AST_WR_LATENCY: assert property (wrBoth |=> !s_axi_bvalid ##1 s_axi_bvalid)
    else $error("write response not two edges after acceptance");
  AST_RD_LATENCY: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data not one edge after acceptance");
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  AST_AR_BLOCK: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken while data pending");
  AST_AW_BLOCK: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  AST_EN_UNUSED: assert property (enRead |=> s_axi_rdata[2:0] == 3'h0 && s_axi_rdata[31:8] == 24'h0)
    else $error("unused enable bits read nonzero");
  AST_READ_CLEARS: assert property (statRead ##0 !frameStrobe |=> !irq || $rose(s_axi_bvalid))
    else $error("interrupt survives event read");
  // A write that disables a monitor raises its event one cycle after the response
  AST_IRQ_CAUSE: assert property ($rose(irq) |->
    $past(frameStrobe) || s_axi_bvalid || $past(s_axi_bvalid))
    else $error("interrupt raised without a cause");
  AST_IRQ_DROP: assert property ($fell(irq) |-> ($past(s_axi_arvalid) && $past(s_axi_arready)) || $rose(s_axi_bvalid))
    else $error("interrupt dropped without read or write");
endmodule
bind abm_monitor abm_monitor_properties chk_u (.clk(clk), .srst(srst), .frameStrobe(frameStrobe),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .irq(irq));
`default_nettype wire

/* File: test/abm_monitor_test.sv */
// Self-checking bench for the BER and APS monitor
`timescale 1ns/1ns
`default_nettype none
`include "abm_defs.vh"
module abm_monitor_test;
  logic clk = 1'b0;
  logic srst = 1'b1;
  // Bus master outputs, idle at time zero
  logic [11:0] awAddr = 12'h0, arAddr = 12'h0;
  logic [31:0] wData = 32'h0;
  logic [3:0] wStrb = 4'hf;
  logic awValid = 1'b0, wValid = 1'b0, bReady = 1'b0, arValid = 1'b0, rReady = 1'b0;
  wire awReady, wReady, bValid, arReady, rValid, irq, frameStrobe;
  wire [1:0] bResp, rResp;
  wire [31:0] rData;
  wire [11:0] b2Err;
  wire [7:0] k1, k2;
  wire [3:0] syncNib;
  int miscompares = 0, num_checks = 0, i;
  logic [7:0] k1v, k2v;
  logic [11:0] thr;
  logic [31:0] cfgv;
  // Notes of expected answers, oldest first
  logic [33:0] rq[$];
  logic [1:0] bq[$];
  always #5 clk = ~clk;
  abm_frame_src src_u (.clk(clk), .frameStrobe(frameStrobe), .b2ErrCount(b2Err),
    .k1Byte(k1), .k2Byte(k2), .syncNibble(syncNib));
  abm_monitor dut_u (.clk(clk), .srst(srst), .frameStrobe(frameStrobe), .b2ErrCount(b2Err),
    .k1Byte(k1), .k2Byte(k2), .syncNibble(syncNib), .s_axi_awaddr(awAddr),
    .s_axi_awvalid(awValid), .s_axi_awready(awReady), .s_axi_wdata(wData), .s_axi_wstrb(wStrb),
    .s_axi_wvalid(wValid), .s_axi_wready(wReady), .s_axi_bresp(bResp), .s_axi_bvalid(bValid),
    .s_axi_bready(bReady), .s_axi_araddr(arAddr), .s_axi_arvalid(arValid),
    .s_axi_arready(arReady), .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid),
    .s_axi_rready(rReady), .irq(irq));
  task check(input logic [33:0] got, input logic [33:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Interrupt line, sampled at the edge before that edge updates it
  task chkIrq(input logic e);
    check({33'h0, irq}, {33'h0, e});
  endtask
  task close_out;
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task hang;
    miscompares++;
    $display("wrong value at %0t: no handshake", $time);
    close_out();
  endtask
  // Write one word; each channel is released at its own ready
  // The response is accepted after a random lag, so it must stand meanwhile
  task wr(input logic [7:0] idx, input logic [31:0] d, input logic [1:0] er = `ABM_RESP_OKAY,
          input logic [3:0] st = 4'hf);
    int n, lag;
    lag = $urandom % 4;
    bq.push_back(er);
    awAddr <= {2'h0, idx, 2'h0};
    wData <= d;
    wStrb <= st;
    awValid <= 1'b1;
    wValid <= 1'b1;
    bReady <= (lag == 0);
    n = 0;
    do begin
      @(posedge clk);
      if (awReady) awValid <= 1'b0;
      if (wReady) wValid <= 1'b0;
      n++;
      if (n == lag) bReady <= 1'b1;
    end while (!(bValid === 1'b1 && bReady === 1'b1) && n < 50);
    bReady <= 1'b0;
    if (bValid !== 1'b1) hang();
    @(posedge clk);
  endtask
  // Read one word and note what should come back
  task rd(input logic [7:0] idx, input logic [31:0] d, input logic [1:0] er = `ABM_RESP_OKAY);
    int n, lag;
    lag = $urandom % 4;
    rq.push_back({er, d});
    arAddr <= {2'h0, idx, 2'h0};
    arValid <= 1'b1;
    rReady <= (lag == 0);
    n = 0;
    do begin
      @(posedge clk);
      if (arReady) arValid <= 1'b0;
      n++;
      if (n == lag) rReady <= 1'b1;
    end while (!(rValid === 1'b1 && rReady === 1'b1) && n < 50);
    rReady <= 1'b0;
    if (rValid !== 1'b1) hang();
    @(posedge clk);
  endtask
  // One frame with the fixed K2 and a random gap after it
  task fr(input logic [7:0] a, input logic [3:0] s, input logic [11:0] e);
    src_u.send(a, k2v, s, e, 1 + $urandom % 3);
  endtask
  // Compare every answer with the oldest note
  always @(posedge clk) begin
    if (rValid === 1'b1 && rReady === 1'b1) check({rResp, rData}, rq.pop_front());
    if (bValid === 1'b1 && bReady === 1'b1) check({32'h0, bResp}, {32'h0, bq.pop_front()});
  end
  initial begin
    void'($urandom(32'h3c803726));
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    k1v = 8'h01 | 8'($urandom);
    k2v = 8'($urandom);
    thr = 12'h2 + 12'($urandom % 100);
    cfgv = $urandom & 32'h37;
    rd(`ABM_IDX_CFG, 32'h0);
    rd(`ABM_IDX_INT_EN, 32'h0);
    wr(`ABM_IDX_INT_EN, 32'hffffffff);
    rd(`ABM_IDX_INT_EN, 32'hf8);
    rd(8'h10, 32'h0, `ABM_RESP_SLVERR);
    wr(8'h10, 32'h1, `ABM_RESP_SLVERR);
    wr(`ABM_IDX_CFG, cfgv);
    rd(`ABM_IDX_CFG, cfgv);
    // Only the strobed byte lanes change
    wr(`ABM_IDX_SF_PER, 32'h00aabbcc, `ABM_RESP_OKAY, 4'h5);
    rd(`ABM_IDX_SF_PER, 32'h00aa00cc);
    wr(`ABM_IDX_CFG, 32'h0);
    // A new code is stored only on its third frame
    fr(k1v, 4'h0, 12'h0);
    fr(k1v, 4'h0, 12'h0);
    chkIrq(1'b0);
    fr(k1v, 4'h0, 12'h0);
    chkIrq(1'b1);
    rd(`ABM_IDX_K1, {24'h0, k1v});
    rd(`ABM_IDX_K2, {24'h0, k2v});
    rd(`ABM_IDX_INT_STAT, 32'h40);
    chkIrq(1'b0);
    fr(k1v, 4'h9, 12'h0);
    chkIrq(1'b1);
    rd(`ABM_IDX_SYNC, 32'h9);
    rd(`ABM_IDX_INT_STAT, 32'h20);
    // Persistent sync needs eight equal frames
    wr(`ABM_IDX_CFG, 32'h80);
    for (i = 0; i < 8; i++) begin
      if (i == 7) rd(`ABM_IDX_INT_STAT, 32'h0);
      fr(k1v, 4'h5, 12'h0);
    end
    rd(`ABM_IDX_INT_STAT, 32'h20);
    wr(`ABM_IDX_CFG, 32'h0);
    // Alternating K1 never forms a triple
    for (i = 0; i < 12; i++) begin
      if (i == 10) rd(`ABM_IDX_INT_STAT, 32'h0);
      fr(i[0] ? k1v : ~k1v, 4'h5, 12'h0);
    end
    chkIrq(1'b1);
    rd(`ABM_IDX_INT_STAT, 32'h81);
    fr(k1v, 4'h5, 12'h0);
    rd(`ABM_IDX_INT_STAT, 32'h01);
    fr(k1v, 4'h5, 12'h0);
    rd(`ABM_IDX_INT_STAT, 32'h80);
    // Degrade: thresholds first, then enable; per-frame cap of two
    wr(`ABM_IDX_SD_PER, 32'h1);
    wr(`ABM_IDX_SD_SAT, 32'h2);
    wr(`ABM_IDX_SD_DECL, 32'h4);
    wr(`ABM_IDX_SD_CLR, 32'h1);
    wr(`ABM_IDX_CFG, 32'h08);
    fr(k1v, 4'h5, 12'h4);
    rd(`ABM_IDX_INT_STAT, 32'h0);
    fr(k1v, 4'h5, 12'h4);
    chkIrq(1'b1);
    rd(`ABM_IDX_INT_STAT, 32'h0a);
    for (i = 0; i < 8; i++) begin
      if (i == 7) rd(`ABM_IDX_INT_STAT, 32'h02);
      fr(k1v, 4'h5, 12'h0);
    end
    rd(`ABM_IDX_INT_STAT, 32'h08);
    // Long clearing window: removal only on the 64th quiet subtotal
    wr(`ABM_IDX_CFG, 32'h0a);
    repeat (2) fr(k1v, 4'h5, 12'h4);
    rd(`ABM_IDX_INT_STAT, 32'h0a);
    for (i = 0; i < 64; i++) begin
      if (i == 63) rd(`ABM_IDX_INT_STAT, 32'h02);
      fr(k1v, 4'h5, 12'h0);
    end
    rd(`ABM_IDX_INT_STAT, 32'h08);
    // Subtotal cap: two frames of four errors count as two
    wr(`ABM_IDX_CFG, 32'h0);
    wr(`ABM_IDX_SD_PER, 32'h2);
    wr(`ABM_IDX_CFG, 32'h0c);
    repeat (2) fr(k1v, 4'h5, 12'h4);
    rd(`ABM_IDX_INT_STAT, 32'h0);
    repeat (2) fr(k1v, 4'h5, 12'h4);
    rd(`ABM_IDX_INT_STAT, 32'h0a);
    // Fail declares exactly at its threshold
    wr(`ABM_IDX_SF_PER, 32'h1);
    wr(`ABM_IDX_SF_SAT, 32'hfff);
    wr(`ABM_IDX_SF_DECL, {20'h0, thr});
    wr(`ABM_IDX_SF_CLR, 32'h1);
    wr(`ABM_IDX_CFG, 32'h40);
    rd(`ABM_IDX_INT_STAT, 32'h08);
    fr(k1v, 4'h5, thr - 12'h1);
    rd(`ABM_IDX_INT_STAT, 32'h0);
    fr(k1v, 4'h5, 12'h1);
    chkIrq(1'b1);
    rd(`ABM_IDX_INT_STAT, 32'h14);
    wr(`ABM_IDX_CFG, 32'h0);
    rd(`ABM_IDX_INT_STAT, 32'h10);
    // Masked event shows in status only
    wr(`ABM_IDX_INT_EN, 32'h0);
    repeat (3) fr(~k1v, 4'h5, 12'h0);
    chkIrq(1'b0);
    rd(`ABM_IDX_INT_STAT, 32'h40);
    close_out();
  end
endmodule
`default_nettype wire
